// [src/dpll_mode_pkg.sv]
// constants, types and register map for the dpll operating mode control
package dpll_mode_pkg;

  // ------------------------------------------------------------
  // clocking and time base
  // ------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 200_000_000;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = CLK_FREQ_HZ / 1_000_000 * TICK_PERIOD_US;

  // ------------------------------------------------------------
  // frequency word scaling (parts per trillion)
  // ------------------------------------------------------------
  localparam int FREQ_LSB_PPT = 500;
  localparam int CAL_LSB_PPT = 100_000;
  localparam logic signed [31:0] CAL_SCALE = 32'(CAL_LSB_PPT / FREQ_LSB_PPT);
  localparam int CAL_WIDTH = 11;
  localparam int RATE_1P0_PPT_S = 1_000_000;
  localparam int RATE_1P5_PPT_S = 1_500_000;
  localparam int RATE_2P0_PPT_S = 2_000_000;
  localparam logic signed [31:0] STEP_1P0 =
    32'(RATE_1P0_PPT_S / 1000 * TICK_PERIOD_US / 1000 / FREQ_LSB_PPT);
  localparam logic signed [31:0] STEP_1P5 =
    32'(RATE_1P5_PPT_S / 1000 * TICK_PERIOD_US / 1000 / FREQ_LSB_PPT);
  localparam logic signed [31:0] STEP_2P0 =
    32'(RATE_2P0_PPT_S / 1000 * TICK_PERIOD_US / 1000 / FREQ_LSB_PPT);

  // ------------------------------------------------------------
  // history filters
  // ------------------------------------------------------------
  localparam int ST_SHIFT_BASE = 2;
  localparam int DEV_SHIFT = 10;

  // ------------------------------------------------------------
  // register map (byte addresses, multi-byte registers lsb first)
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_CAL = 7'h0E;
  localparam logic [6:0] ADDR_CTRL [2] = '{7'h1C, 7'h39};
  localparam logic [6:0] ADDR_BW [2] = '{7'h1D, 7'h3A};
  localparam logic [6:0] ADDR_ST_HIST [2] = '{7'h28, 7'h45};
  localparam logic [6:0] ADDR_USER [2] = '{7'h2C, 7'h49};
  localparam logic [6:0] ADDR_RAMP [2] = '{7'h30, 7'h4D};
  localparam logic [15:0] CAL_RESET = 16'h0000;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BW_RESET = 8'h00;
  localparam logic [7:0] RAMP_RESET = 8'h00;
  localparam logic [7:0] BW_CODE_SLAVE = 8'hFF;

  // ------------------------------------------------------------
  // reference codes
  // ------------------------------------------------------------
  localparam int NUM_REFS = 12;
  localparam logic [3:0] REF_XSYNC = 4'hC;
  localparam logic [3:0] REF_PRIMARY = 4'hD;

  // ------------------------------------------------------------
  // register layouts
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] manual_ref;
    logic auto_select;
    logic pullin_overrange_follow;
    logic holdover_source_select;
    logic phase_align;
  } gen_ctrl_t;

  typedef struct packed {
    logic revertive;
    logic [2:0] long_term_bw;
    logic [1:0] short_term_bw;
    logic [1:0] ramp_rate;
  } ramp_cfg_t;

  typedef enum logic [1:0] {
    RAMP_NONE = 2'h0,
    RAMP_1P0 = 2'h1,
    RAMP_1P5 = 2'h2,
    RAMP_2P0 = 2'h3
  } ramp_rate_t;

  typedef enum logic [1:0] {
    OP_FREERUN = 2'h0,
    OP_HOLDOVER = 2'h1,
    OP_SYNC = 2'h2
  } op_req_t;

  typedef enum logic [4:0] {
    ST_FREERUN = 5'b00001,
    ST_HOLDOVER = 5'b00010,
    ST_PULLIN = 5'b00100,
    ST_LOCKED = 5'b01000,
    ST_ZOMBIE = 5'b10000
  } gen_state_t;

  // loop status from one generator's phase detector
  typedef struct packed {
    logic ref_los;
    logic loop_lock;
    logic signed [31:0] ref_offset;
  } loop_stat_t;

endpackage : dpll_mode_pkg

// [src/dpll_operating_mode_control.sv]
// operating mode control for the primary and secondary timing generators
`timescale 1ns/1ps
module dpll_operating_mode_control #(
  parameter int TICK_LEN = dpll_mode_pkg::TICK_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_n_o,
  input wire logic [1:0] ms_select_n_i,
  input wire logic [1:0][1:0] op_req_i,
  input wire dpll_mode_pkg::loop_stat_t [1:0] loop_stat_i,
  input wire logic [dpll_mode_pkg::NUM_REFS-1:0] ref_qualified_i,
  input wire logic [31:0] pullin_range_i,
  output dpll_mode_pkg::gen_state_t [1:0] gen_state_o,
  output logic [1:0] slave_o,
  output logic [1:0][3:0] ref_sel_o,
  output logic [1:0] phase_lock_o,
  output logic [1:0] phase_rebuild_o,
  output logic [1:0][7:0] loop_bw_o,
  output logic [1:0][31:0] xref_freq_o,
  output logic [8:0][31:0] clk_freq_o
);
  import dpll_mode_pkg::*;

  // ------------------------------------------------------------
  // reset release and pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [2:0] spi_s3_q;

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= 5'b11011;
      pin_s2_q <= 5'b11011;
      spi_s3_q <= 3'b010;
    end
    else
    begin
      pin_s1_q <= {ms_select_n_i, spi_sclk_i, spi_cs_n_i, spi_mosi_i};
      pin_s2_q <= pin_s1_q;
      spi_s3_q <= pin_s2_q[2:0];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  assign cs_active = !pin_s2_q[1];
  assign sclk_rise = pin_s2_q[2] && !spi_s3_q[2];
  assign sclk_fall = !pin_s2_q[2] && spi_s3_q[2];

  // ------------------------------------------------------------
  // millisecond tick
  // ------------------------------------------------------------
  logic [31:0] tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == 32'(TICK_LEN - 1));

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_q <= '0;
    else if (tick)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + 32'd1;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [15:0] cal_q;
  gen_ctrl_t [1:0] ctrl_q;
  logic [1:0][7:0] bw_q;
  logic [1:0][31:0] user_q;
  ramp_cfg_t [1:0] ramp_q;
  logic signed [31:0] st_hist_q [2];
  logic signed [31:0] dev_hist_q [2];

  // ------------------------------------------------------------
  // spi slave: first byte is read flag and address, then data
  // ------------------------------------------------------------
  logic [2:0] bit_cnt_q;
  logic [7:0] sh_in_q;
  logic [7:0] sh_out_q;
  logic [6:0] addr_q;
  logic cmd_done_q;
  logic read_q;
  logic [7:0] byte_in;
  logic byte_done;
  logic wr_stb;
  logic [7:0] rd_byte;
  logic [6:0] rd_addr;

  assign byte_in = {sh_in_q[6:0], pin_s2_q[0]};
  assign byte_done = cs_active && sclk_rise && (bit_cnt_q == 3'd7);
  assign wr_stb = byte_done && cmd_done_q && !read_q;
  assign rd_addr = cmd_done_q ? addr_q : byte_in[6:0];

  function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [6:0] off);
    pick_byte = w[8*off[1:0] +: 8];
  endfunction : pick_byte

  always_comb
  begin
    rd_byte = '0;
    if (rd_addr == ADDR_CAL)
      rd_byte = cal_q[7:0];
    if (rd_addr == ADDR_CAL + 7'd1)
      rd_byte = cal_q[15:8];
    for (int g = 0; g < 2; g++)
    begin
      if (rd_addr == ADDR_CTRL[g])
        rd_byte = ctrl_q[g];
      if (rd_addr == ADDR_BW[g])
        rd_byte = bw_q[g];
      if (rd_addr == ADDR_RAMP[g])
        rd_byte = ramp_q[g];
      if (rd_addr - ADDR_USER[g] < 7'd4)
        rd_byte = pick_byte(user_q[g], rd_addr - ADDR_USER[g]);
      if (rd_addr - ADDR_ST_HIST[g] < 7'd4)
        rd_byte = pick_byte(st_hist_q[g], rd_addr - ADDR_ST_HIST[g]);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt_q <= '0;
      sh_in_q <= '0;
      sh_out_q <= '0;
      addr_q <= '0;
      cmd_done_q <= 1'b0;
      read_q <= 1'b0;
    end
    else if (!cs_active)
    begin
      bit_cnt_q <= '0;
      cmd_done_q <= 1'b0;
    end
    else if (sclk_rise)
    begin
      bit_cnt_q <= bit_cnt_q + 3'd1;
      sh_in_q <= byte_in;
      if (byte_done)
      begin
        cmd_done_q <= 1'b1;
        sh_out_q <= rd_byte;
        if (!cmd_done_q)
        begin
          read_q <= byte_in[7];
          addr_q <= byte_in[6:0] + 7'(byte_in[7]);
        end
        else
          addr_q <= addr_q + 7'd1;
      end
    end
    else if (sclk_fall && bit_cnt_q != 3'd0)
      sh_out_q <= {sh_out_q[6:0], 1'b0};
  end

  assign spi_miso_o = sh_out_q[7];
  assign spi_miso_oe_n_o = !(cs_active && read_q && cmd_done_q);

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cal_q <= CAL_RESET;
      ctrl_q <= {2{CTRL_RESET}};
      bw_q <= {2{BW_RESET}};
      user_q <= '0;
      ramp_q <= {2{RAMP_RESET}};
    end
    else if (wr_stb)
    begin
      if (addr_q == ADDR_CAL)
        cal_q[7:0] <= byte_in;
      if (addr_q == ADDR_CAL + 7'd1)
        cal_q[15:8] <= byte_in;
      for (int g = 0; g < 2; g++)
      begin
        if (addr_q == ADDR_CTRL[g])
          ctrl_q[g] <= byte_in;
        if (addr_q == ADDR_BW[g])
          bw_q[g] <= byte_in;
        if (addr_q == ADDR_RAMP[g])
          ramp_q[g] <= byte_in;
        for (int b = 0; b < 4; b++)
        begin
          if (addr_q == ADDR_USER[g] + 7'(b))
            user_q[g][8*b +: 8] <= byte_in;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // calibrated freerun frequency
  // ------------------------------------------------------------
  logic signed [31:0] cal_word;
  assign cal_word = $signed({{(32-CAL_WIDTH){cal_q[CAL_WIDTH-1]}},
    cal_q[CAL_WIDTH-1:0]}) * CAL_SCALE;

  // ------------------------------------------------------------
  // per generator mode control
  // ------------------------------------------------------------
  logic signed [31:0] freq_q [2];

  for (genvar g = 0; g < 2; g++)
  begin : gen_tg
    gen_state_t state_q;
    gen_state_t state_d;
    logic slave;
    logic align;
    logic follow;
    logic [1:0] self_q;
    logic [1:0] self_d;
    logic ramp_go;
    logic ramp_act_q;
    logic [3:0] sel_d;
    logic [3:0] sel_q;
    logic signed [31:0] offs;
    logic signed [31:0] target;
    logic signed [31:0] step;
    logic signed [31:0] diff;
    logic signed [31:0] rel;
    loop_stat_t ls;

    assign ls = loop_stat_i[g];
    assign slave = !pin_s2_q[3+g];
    assign align = slave || ctrl_q[g].phase_align;
    assign follow = slave || ctrl_q[g].pullin_overrange_follow;

    // reference choice
    always_comb
    begin
      sel_d = sel_q;
      if (slave)
        sel_d = REF_XSYNC;
      else if (!ctrl_q[g].auto_select)
      begin
        if (ctrl_q[g].manual_ref < 4'(NUM_REFS) || ctrl_q[g].manual_ref == REF_XSYNC
            || (g == 1 && ctrl_q[g].manual_ref == REF_PRIMARY))
          sel_d = ctrl_q[g].manual_ref;
      end
      else if (!(ramp_q[g].revertive == 1'b0 && sel_q < 4'(NUM_REFS)
          && ref_qualified_i[sel_q]))
      begin
        for (int r = NUM_REFS - 1; r >= 0; r--)
        begin
          if (ref_qualified_i[r])
            sel_d = 4'(r);
        end
      end
    end

    // operating state
    always_comb
    begin
      state_d = state_q;
      if (!(slave || op_req_t'(op_req_i[g]) == OP_SYNC))
        state_d = (op_req_t'(op_req_i[g]) == OP_HOLDOVER) ? ST_HOLDOVER : ST_FREERUN;
      else if (sel_d != sel_q || state_q == ST_FREERUN || state_q == ST_HOLDOVER)
        state_d = ST_PULLIN;
      else
      begin
        unique case (state_q)
          ST_PULLIN:
            if (ls.ref_los)
              state_d = ST_ZOMBIE;
            else if (ls.loop_lock)
              state_d = ST_LOCKED;
          ST_LOCKED:
            if (ls.ref_los)
              state_d = ST_ZOMBIE;
            else if (!ls.loop_lock)
              state_d = ST_PULLIN;
          ST_ZOMBIE:
            if (!ls.ref_los)
              state_d = ST_PULLIN;
          default:
            state_d = ST_PULLIN;
        endcase
      end
    end

    // target frequency, relative to oscillator
    always_comb
    begin
      offs = ls.ref_offset;
      if (!follow && offs > $signed(pullin_range_i))
        offs = $signed(pullin_range_i);
      else if (!follow && offs < -$signed(pullin_range_i))
        offs = -$signed(pullin_range_i);
      unique case (state_q)
        ST_FREERUN:
          target = cal_word;
        ST_HOLDOVER:
          target = cal_word + (ctrl_q[g].holdover_source_select ?
            $signed(user_q[g]) : dev_hist_q[g]);
        ST_ZOMBIE:
          target = cal_word + st_hist_q[g];
        default:
          target = cal_word + offs;
      endcase
    end

    always_comb
    begin
      unique case (ramp_rate_t'(ramp_q[g].ramp_rate))
        RAMP_1P0: step = STEP_1P0;
        RAMP_1P5: step = STEP_1P5;
        RAMP_2P0: step = STEP_2P0;
        RAMP_NONE: step = '0;
      endcase
    end

    assign diff = target - freq_q[g];
    assign rel = freq_q[g] - cal_word;
    // mode class: external, freerun or holdover; any class change ramps
    assign self_d = {state_q == ST_HOLDOVER, state_q == ST_FREERUN};
    assign ramp_go = self_q != self_d;

    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
      if (!rst_n)
      begin
        state_q <= ST_FREERUN;
        sel_q <= '0;
        self_q <= 2'b01;
      end
      else
      begin
        state_q <= state_d;
        sel_q <= sel_d;
        self_q <= self_d;
      end
    end

    // frequency ramp limiter
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
      if (!rst_n)
      begin
        ramp_act_q <= 1'b0;
        freq_q[g] <= '0;
      end
      else
      begin
        if (ramp_go)
          ramp_act_q <= 1'b1;
        else if (diff == '0)
          ramp_act_q <= 1'b0;
        if ((!ramp_act_q && !ramp_go) || step == '0)
          freq_q[g] <= target;
        else if (tick)
        begin
          if (diff > step)
            freq_q[g] <= freq_q[g] + step;
          else if (diff < -step)
            freq_q[g] <= freq_q[g] - step;
          else
            freq_q[g] <= target;
        end
      end
    end

    // history filters
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
      if (!rst_n)
      begin
        st_hist_q[g] <= '0;
        dev_hist_q[g] <= '0;
      end
      else if (tick)
      begin
        if (state_q != ST_ZOMBIE)
          st_hist_q[g] <= st_hist_q[g] + ((rel - st_hist_q[g])
            >>> (ST_SHIFT_BASE + int'(ramp_q[g].short_term_bw)));
        if (state_q == ST_LOCKED)
          dev_hist_q[g] <= dev_hist_q[g] + ((rel - dev_hist_q[g]) >>> DEV_SHIFT);
      end
    end

    // phase mode and outputs
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
      if (!rst_n)
      begin
        phase_lock_o[g] <= 1'b0;
        phase_rebuild_o[g] <= 1'b0;
        loop_bw_o[g] <= '0;
        ref_sel_o[g] <= '0;
        xref_freq_o[g] <= '0;
      end
      else
      begin
        phase_lock_o[g] <= align || state_d == ST_LOCKED;
        phase_rebuild_o[g] <= !align && state_q == ST_PULLIN
          && state_d == ST_LOCKED;
        loop_bw_o[g] <= slave ? BW_CODE_SLAVE : bw_q[g];
        ref_sel_o[g] <= sel_d;
        xref_freq_o[g] <= freq_q[g];
      end
    end

    assign gen_state_o[g] = state_q;
    assign slave_o[g] = slave;
  end

  // ------------------------------------------------------------
  // clock output sourcing
  // ------------------------------------------------------------
  for (genvar c = 0; c < 9; c++)
  begin : gen_clk
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
      if (!rst_n)
        clk_freq_o[c] <= '0;
      else
        clk_freq_o[c] <= freq_q[(c == 7) ? 1 : 0];
    end
  end

endmodule : dpll_operating_mode_control

// [testbench/dpll_mode_properties.sv]
// port assertions for the dpll operating mode control
`timescale 1ns/1ps
module dpll_mode_properties
  import dpll_mode_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [1:0][1:0] op_req_i,
  input wire dpll_mode_pkg::loop_stat_t [1:0] loop_stat_i,
  input wire dpll_mode_pkg::gen_state_t [1:0] gen_state_o,
  input wire logic [1:0] slave_o,
  input wire logic [1:0][3:0] ref_sel_o,
  input wire logic [1:0] phase_lock_o,
  input wire logic [1:0] phase_rebuild_o,
  input wire logic [1:0][7:0] loop_bw_o,
  input wire logic [8:0][31:0] clk_freq_o
);
  // ----------
  // settle time after reset
  // ----------
  logic [2:0] live_q;
  logic ok;
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      live_q <= 3'h0;
    else if (live_q != 3'h7)
      live_q <= live_q + 3'h1;
  assign ok = live_q == 3'h7;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // ----------
  // properties
  // ----------
  property p_freerun;
    ok && !slave_o[0] && op_req_i[0] == OP_FREERUN |=> gen_state_o[0] == ST_FREERUN;
  endproperty
  a_freerun: assert property (p_freerun) else $error("freerun not entered");
  property p_holdover;
    ok && !slave_o[0] && op_req_i[0] == OP_HOLDOVER |=> gen_state_o[0] == ST_HOLDOVER;
  endproperty
  a_holdover: assert property (p_holdover) else $error("holdover not entered");
  property p_pullin;
    ok && !slave_o[0] && op_req_i[0] == OP_SYNC
      && gen_state_o[0] inside {ST_FREERUN, ST_HOLDOVER} |=> gen_state_o[0] == ST_PULLIN;
  endproperty
  a_pullin: assert property (p_pullin) else $error("no pull-in");
  property p_zombie;
    ok && gen_state_o[0] == ST_LOCKED && op_req_i[0] == OP_SYNC && loop_stat_i[0].ref_los
      |=> gen_state_o[0] == ST_ZOMBIE;
  endproperty
  a_zombie: assert property (p_zombie) else $error("no zombie on loss");
  property p_rebuild;
    phase_rebuild_o[0] |-> gen_state_o[0] == ST_LOCKED && $past(gen_state_o[0]) == ST_PULLIN
      ##1 !phase_rebuild_o[0];
  endproperty
  a_rebuild: assert property (p_rebuild) else $error("bad rebuild pulse");
  property p_freq_first;
    phase_rebuild_o[0] |-> !$past(phase_lock_o[0]) ##[0:1] phase_lock_o[0];
  endproperty
  a_freq_first: assert property (p_freq_first) else $error("rebuild not from freq lock");
  property p_slave_bw;
    ok && $past(slave_o[0], 2) && slave_o[0] |-> loop_bw_o[0] == BW_CODE_SLAVE;
  endproperty
  a_slave_bw: assert property (p_slave_bw) else $error("slave bandwidth wrong");
  property p_slave_lock;
    ok && $past(slave_o[0], 2) && slave_o[0] && gen_state_o[0] inside {ST_PULLIN, ST_LOCKED}
      |-> phase_lock_o[0];
  endproperty
  a_slave_lock: assert property (p_slave_lock) else $error("slave not aligned");
  property p_slave_ref;
    ok && $past(slave_o[1], 2) && slave_o[1] && gen_state_o[1] inside {ST_PULLIN, ST_LOCKED}
      |-> ref_sel_o[1] == REF_XSYNC;
  endproperty
  a_slave_ref: assert property (p_slave_ref) else $error("slave ref wrong");
  property p_outputs;
    ok |-> clk_freq_o[1] == clk_freq_o[0] && clk_freq_o[2] == clk_freq_o[0]
      && clk_freq_o[3] == clk_freq_o[0] && clk_freq_o[4] == clk_freq_o[0]
      && clk_freq_o[5] == clk_freq_o[0] && clk_freq_o[6] == clk_freq_o[0]
      && clk_freq_o[8] == clk_freq_o[0];
  endproperty
  a_outputs: assert property (p_outputs) else $error("primary outputs differ");
endmodule : dpll_mode_properties

bind dpll_operating_mode_control dpll_mode_properties i_dpll_mode_properties (
  .sys_clk_i(sys_clk_i),
  .arst_n_i(arst_n_i),
  .op_req_i(op_req_i),
  .loop_stat_i(loop_stat_i),
  .gen_state_o(gen_state_o),
  .slave_o(slave_o),
  .ref_sel_o(ref_sel_o),
  .phase_lock_o(phase_lock_o),
  .phase_rebuild_o(phase_rebuild_o),
  .loop_bw_o(loop_bw_o),
  .clk_freq_o(clk_freq_o)
);

// [testbench/dpll_operating_mode_control_bench.sv]
// self-checking bench for the dpll operating mode control
`timescale 1ns/1ps
module dpll_operating_mode_control_bench;
  import dpll_mode_pkg::*;
  localparam int TICK = 20;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic sclk = 1'b0;
  logic cs_n = 1'b1;
  logic mosi = 1'b0;
  logic miso, miso_oe_n;
  logic [1:0] ms_n, slv, plock, rebuild;
  logic [1:0] slave_req = 2'b00;
  logic [1:0] los = 2'b00;
  logic [1:0][1:0] op_req = '0;
  loop_stat_t [1:0] stat;
  logic [11:0] qual = 12'h000;
  logic [31:0] prange = 32'h64;
  logic [31:0] ofs = 32'h3E8;
  gen_state_t [1:0] st;
  logic [1:0][3:0] rsel;
  logic [1:0][7:0] bw;
  logic [1:0][31:0] xref;
  logic [8:0][31:0] cf;
  logic [31:0] rd, f0, ex;
  logic [15:0] cals [2] = '{16'h03FF, 16'h0400};
  int failures = 0;
  int compares = 0;

  always #2.5 sys_clk = ~sys_clk;

  dpll_operating_mode_control #(.TICK_LEN(TICK)) i_dpll_operating_mode_control (
    .sys_clk_i(sys_clk), .arst_n_i(arst_n), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_n_o(miso_oe_n),
    .ms_select_n_i(ms_n), .op_req_i(op_req), .loop_stat_i(stat), .ref_qualified_i(qual),
    .pullin_range_i(prange), .gen_state_o(st), .slave_o(slv), .ref_sel_o(rsel),
    .phase_lock_o(plock), .phase_rebuild_o(rebuild), .loop_bw_o(bw), .xref_freq_o(xref),
    .clk_freq_o(cf)
  );

  for (genvar g = 0; g < 2; g++)
  begin : gen_far
    loop_partner_model #(.LOCK_DLY(g ? 2 : 40)) i_loop_partner_model (
      .sys_clk_i(sys_clk), .state_i(st[g]), .los_i(los[g]), .slave_i(slave_req[g]),
      .offset_i(ofs), .stat_o(stat[g]), .ms_select_n_o(ms_n[g])
    );
  end

  // ----------
  // tasks
  // ----------
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // header byte, then n data bytes lsb first
  task spi(input logic [7:0] hdr, input int n, input logic [31:0] wd);
    logic [7:0] b;
    rd = '0;
    cs_n = 1'b0;
    cyc(6);
    for (int k = -1; k < n; k++)
      for (int i = 7; i >= 0; i--)
      begin
        b = (k < 0) ? hdr : wd[8*k +: 8];
        mosi = b[i];
        cyc(6);
        if (k >= 0)
          rd[8*k+i] = miso;
        if (k == 0 && i == 7)
          chk(32'(miso_oe_n), 32'(!hdr[7]));
        sclk = 1'b1;
        cyc(6);
        sclk = 1'b0;
      end
    cyc(6);
    cs_n = 1'b1;
    cyc(8);
  endtask : spi

  task wr(input logic [6:0] a, input int n, input logic [31:0] d);
    spi({1'b0, a}, n, d);
  endtask : wr

  task rdc(input logic [6:0] a, input int n, input logic [31:0] exp);
    spi({1'b1, a}, n, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task wst(input int g, input gen_state_t s);
    for (int i = 0; i < 400 && st[g] !== s; i++)
      cyc(1);
    chk(32'(st[g]), 32'(s));
  endtask : wst

  task complete_run;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    complete_run();
  end

  // ----------
  // tests
  // ----------
  initial
  begin
    cyc(12);
    arst_n = 1'b1;
    cyc(10);
    for (int g = 0; g < 2; g++)
    begin
      rdc(ADDR_CTRL[g], 1, 32'(CTRL_RESET));
      rdc(ADDR_RAMP[g], 1, 32'(RAMP_RESET));
      wr(ADDR_ST_HIST[g], 4, 32'hA5A5_A5A5);
      rdc(ADDR_ST_HIST[g], 4, 32'h0);
      rdc(ADDR_USER[g], 4, 32'h0);
      wr(ADDR_USER[g], 4, 32'h1234_5678);
      rdc(ADDR_USER[g], 4, 32'h1234_5678);
      rdc(ADDR_BW[g], 1, 32'(BW_RESET));
      wr(ADDR_BW[g], 1, 32'h35);
      chk(32'(bw[g]), 32'h35);
    end
    wr(7'h00, 1, 32'h5A);
    rdc(7'h00, 1, 32'h0);
    rdc(ADDR_CAL, 2, 32'(CAL_RESET));
    // calibration extremes, freerun on both generators
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_CAL, 2, 32'(cals[i]));
      rdc(ADDR_CAL, 2, 32'(cals[i]));
      ex = 32'($signed(cals[i][10:0])) * CAL_SCALE;
      chk(cf[0], ex);
      chk(cf[7], ex);
      chk(xref[0], ex);
      chk(xref[1], ex);
    end
    wr(ADDR_CAL, 2, 32'h0);
    // holdover from user and device history, no ramp
    wr(ADDR_USER[0], 4, 32'h40);
    wr(ADDR_CTRL[0], 1, 32'h02);
    op_req[0] = OP_HOLDOVER;
    wst(0, ST_HOLDOVER);
    cyc(3);
    chk(cf[3], 32'h40);
    wr(ADDR_CTRL[0], 1, 32'h00);
    chk(cf[3], 32'h0);
    wr(ADDR_CTRL[0], 1, 32'h02);
    op_req[0] = OP_FREERUN;
    cyc(3);
    chk(cf[3], 32'h0);
    // step per tick is 2, 3, 4 lsb for 1, 1.5, 2 ppm/s
    for (int c = 1; c < 4; c++)
    begin
      wr(ADDR_RAMP[0], 1, 32'(c));
      op_req[0] = OP_HOLDOVER;
      cyc(30);
      f0 = cf[0];
      cyc(10 * TICK);
      chk(cf[0] - f0, 32'(10 * (c + 1)));
      op_req[0] = OP_FREERUN;
      cyc(40 * TICK);
      chk(cf[0], 32'h0);
    end
    wr(ADDR_RAMP[0], 1, 32'h0);
    // arbitrary phase, manual ref 3, clamp beyond pull-in range
    wr(ADDR_CTRL[0], 1, 32'h30);
    op_req[0] = OP_SYNC;
    cyc(3);
    chk(32'(st[0]), 32'(ST_PULLIN));
    chk(32'(plock[0]), 32'h0);
    chk(32'(rsel[0]), 32'h3);
    wst(0, ST_LOCKED);
    chk(32'(plock[0]), 32'h1);
    chk(cf[0], prange);
    wr(ADDR_CTRL[0], 1, 32'h34);
    chk(cf[0], ofs);
    wr(ADDR_CTRL[0], 1, 32'h55);
    chk(32'(st[0]), 32'(ST_PULLIN));
    chk(32'(plock[0]), 32'h1);
    wst(0, ST_LOCKED);
    los[0] = 1'b1;
    wst(0, ST_ZOMBIE);
    los[0] = 1'b0;
    // selection: auto by qualification, manual regardless
    qual = 12'h044;
    wr(ADDR_CTRL[0], 1, 32'h08);
    chk(32'(rsel[0]), 32'h2);
    qual = 12'h000;
    wr(ADDR_CTRL[0], 1, 32'h70);
    chk(32'(rsel[0]), 32'h7);
    wr(ADDR_CTRL[0], 1, 32'hD0);
    chk(32'(rsel[0]), 32'h7);
    op_req[1] = OP_SYNC;
    wr(ADDR_CTRL[1], 1, 32'hD0);
    chk(32'(rsel[1]), 32'(REF_PRIMARY));
    // slave on both generators, follow bit still clear
    slave_req = 2'b11;
    cyc(6);
    chk(32'(slv), 32'h3);
    chk(32'(bw[0]), 32'(BW_CODE_SLAVE));
    wst(0, ST_LOCKED);
    chk(32'(rsel[0]), 32'(REF_XSYNC));
    chk(32'(rsel[1]), 32'(REF_XSYNC));
    chk(32'(plock[0]), 32'h1);
    chk(cf[0], ofs);
    slave_req = 2'b00;
    cyc(6);
    chk(32'(bw[0]), 32'h35);
    complete_run();
  end
endmodule : dpll_operating_mode_control_bench

// [testbench/loop_partner_model.sv]
// far side of one generator: loop status and master/slave pin
`timescale 1ns/1ps
module loop_partner_model
  import dpll_mode_pkg::*;
#(
  parameter int LOCK_DLY = 8
) (
  input wire logic sys_clk_i,
  input wire dpll_mode_pkg::gen_state_t state_i,
  input wire logic los_i,
  input wire logic slave_i,
  input wire logic [31:0] offset_i,
  output dpll_mode_pkg::loop_stat_t stat_o,
  output logic ms_select_n_o
);
  // lock only after a pull-in delay
  int cnt_q = 0;
  always_ff @(posedge sys_clk_i)
    if (state_i != ST_PULLIN || los_i)
      cnt_q <= 0;
    else if (cnt_q < LOCK_DLY)
      cnt_q <= cnt_q + 1;
  assign stat_o = {los_i, !los_i && (state_i == ST_LOCKED || cnt_q >= LOCK_DLY), offset_i};
  assign ms_select_n_o = !slave_i;
endmodule : loop_partner_model
